// *** logic/ptr_params.svh ***
// Register offsets, field positions, reset values and sizes of the pressure threshold block.
`ifndef PTR_PARAMS_SVH
`define PTR_PARAMS_SVH
`define PTR_ADDR_W 7
`define PTR_OFS_IRQ_SETUP 7'h0B
`define PTR_OFS_THS_LOW 7'h0C
`define PTR_OFS_THS_HIGH 7'h0D
`define PTR_OFS_IF_CTRL 7'h0E
`define PTR_OFS_IDENTITY 7'h0F
`define PTR_OFS_CTRL_ONE 7'h10
`define PTR_OFS_CTRL_TWO 7'h11
`define PTR_OFS_CTRL_THREE 7'h12
`define PTR_OFS_FIFO_SETUP 7'h13
`define PTR_OFS_FIFO_WATERMARK_LEVEL 7'h14
`define PTR_OFS_REF_LOW 7'h15
`define PTR_OFS_REF_HIGH 7'h16
`define PTR_OFS_OFFSET_LOW 7'h18
`define PTR_OFS_OFFSET_HIGH 7'h19
`define PTR_OFS_IRQ_CAUSE 7'h24
`define PTR_OFS_FIFO_ST_ONE 7'h25
`define PTR_OFS_FIFO_ST_TWO 7'h26
`define PTR_OFS_STATUS 7'h27
`define PTR_OFS_PRESS_LSB 7'h28
`define PTR_OFS_PRESS_MID 7'h29
`define PTR_OFS_PRESS_MSB 7'h2A
`define PTR_OFS_TEMP_LSB 7'h2B
`define PTR_OFS_TEMP_MSB 7'h2C
`define PTR_OFS_FILTER_RES 7'h3C
`define PTR_OFS_QP_LSB 7'h78
`define PTR_OFS_QP_MID 7'h79
`define PTR_OFS_QP_MSB 7'h7A
`define PTR_OFS_QT_LSB 7'h7B
`define PTR_OFS_QT_MSB 7'h7C
`define PTR_BIT_AUTO_REF 7
`define PTR_BIT_CLR_REF 6
`define PTR_BIT_ZEROED 5
`define PTR_BIT_CLR_ZEROED 4
`define PTR_BIT_DELTA_EN 3
`define PTR_BIT_LATCH 2
`define PTR_BIT_LOW_EN 1
`define PTR_BIT_HIGH_EN 0
`define PTR_CAUSE_ACTIVE 2
`define PTR_CAUSE_LOW 1
`define PTR_CAUSE_HIGH 0
`define PTR_RST_ZERO 8'h00
`define PTR_RST_CTRL_TWO 8'h10
`define PTR_THS_W 15
`define PTR_PRESS_W 24
`define PTR_REF_W 16
`endif

// *** logic/ptr_pkg.sv ***
// Types shared by the pressure threshold block.
package ptr_pkg;
  typedef logic [7:0] ptr_byte_t;
  typedef logic [23:0] ptr_press_t;
  typedef enum logic [1:0] {
    PTR_REF_NONE = 2'b00,
    PTR_REF_ZEROED = 2'b01,
    PTR_REF_AUTO = 2'b10
  } ptr_ref_mode_t;
endpackage

// *** logic/ptr_delta_cmp.sv ***
// Comparator of the pressure difference against the threshold.
`timescale 1ns/1ps
`include "ptr_params.svh"
module ptr_delta_cmp (
  input wire logic signed [24:0] delta,
  input wire logic [14:0] threshold,
  input wire logic high_en,
  input wire logic low_en,
  output logic high_hit,
  output logic low_hit
);
  logic signed [24:0] ths_ext;
  assign ths_ext = {10'h000, threshold};
  assign high_hit = high_en && (delta > ths_ext); // see RULE_08
  assign low_hit = low_en && (delta < ths_ext); // see RULE_09
endmodule

// *** logic/ptr_boot_load.sv ***
// Reloads factory calibration values after power-up.
`timescale 1ns/1ps
`include "ptr_params.svh"
module ptr_boot_load (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [15:0] calib_value,
  output logic boot_done,
  output logic [15:0] calib_q
);
  typedef struct packed {
    logic done;
    logic [15:0] calib;
  } ptr_boot_t;
  ptr_boot_t st_q;
  ptr_boot_t st_d;
  // The calibration value is taken by a clocked load after reset release, never by the reset.
  always_comb begin
    st_d = st_q;
    if (!st_q.done) begin
      st_d.calib = calib_value; // see RULE_04
      st_d.done = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign boot_done = st_q.done;
  assign calib_q = st_q.calib;
endmodule

// *** logic/ptr_regs.sv ***
// Register bank with differential pressure threshold events and reference capture.
// Functional notes
// RULE_01 - Each 8-bit register is selected by a 7-bit address on the serial port.
// RULE_02 - Host never writes reserved ranges; such writes are ignored here.
// RULE_03 - Host never accesses unmapped addresses; they read as zero.
// RULE_04 - Factory calibration is reloaded at every power-up; host leaves it alone.
// RULE_05 - Setup register holds the eight mode and enable bits, all reset to zero.
// RULE_06 - Threshold events need delta enable and at least one event enable.
// RULE_07 - Threshold is a 15-bit unsigned value from two bytes, hPa times 16.
// RULE_08 - High event requested when compared difference exceeds the threshold.
// RULE_09 - Low event requested when compared difference is below the threshold.
// RULE_10 - Latch bit holds events in the cause register; otherwise they follow.
// RULE_11 - Host uses threshold events only with zeroed or auto-reference mode.
// RULE_12 - Zeroed mode captures measured pressure into the two reference registers.
// RULE_13 - Zeroed mode outputs pressure minus reference and compares the same value.
// RULE_14 - Zeroed enable bit clears itself after the first conversion following set.
// RULE_15 - Zeroed reset returns output to normal and clears the reference to zero.
// RULE_16 - Auto-reference captures pressure as reference and compares pressure minus it.
// RULE_17 - Auto-reference leaves the output registers showing raw pressure.
// RULE_18 - Auto-reference bit clears itself after first conversion; its reset ends mode.
// RULE_19 - Comparison happens once per completed conversion using its difference.
`timescale 1ns/1ps
`include "ptr_params.svh"
module ptr_regs #(
  parameter logic [7:0] IDENTITY_VALUE = 8'h5A
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic [23:0] conv_pressure,
  input wire logic [15:0] conv_temperature,
  input wire logic [15:0] calib_value,
  input wire logic [7:0] fifo_status_one,
  input wire logic [7:0] fifo_status_two,
  input wire logic [7:0] status_value,
  input wire logic [23:0] queued_pressure,
  input wire logic [15:0] queued_temperature,
  output logic [7:0] ctrl_one,
  output logic [7:0] ctrl_two,
  output logic [7:0] ctrl_three,
  output logic [7:0] fifo_setup,
  output logic [7:0] fifo_watermark,
  output logic [7:0] interface_ctrl,
  output logic irq_event,
  output logic boot_done
);
  // The identity value is arbitrary.
  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] ths_low;
    logic [7:0] ths_high;
    logic [7:0] if_ctrl;
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] ctrl_three;
    logic [7:0] fifo_setup;
    logic [7:0] fifo_watermark_level;
    logic [15:0] reference;
    logic [7:0] offset_low;
    logic [7:0] offset_high;
    logic [2:0] cause;
    logic [23:0] pressure_result;
    logic [15:0] temp_out;
    ptr_pkg::ptr_ref_mode_t mode;
    logic [7:0] rdata;
  } ptr_state_t;

  ptr_state_t st_q;
  ptr_state_t st_d;
  logic signed [24:0] delta;
  logic [23:0] ref_ext;
  logic [23:0] diff_raw;
  logic high_hit;
  logic low_hit;
  logic cmp_active;
  logic [15:0] calib_q;

  function automatic logic [23:0] ptr_diff(input logic [23:0] a, input logic [23:0] b);
    ptr_diff = a - b;
  endfunction

  // The 16-bit reference lines up with the top bits of the 24-bit pressure word.
  assign ref_ext = {st_q.reference, 8'h00};
  // Capture conversions still see the previous reference here; their events are suppressed below.
  assign diff_raw = ptr_diff(conv_pressure, ref_ext);
  assign delta = (st_q.mode == ptr_pkg::PTR_REF_NONE) ? $signed({1'b0, conv_pressure}) :
                 $signed({diff_raw[23], diff_raw});
  assign cmp_active = st_q.setup[`PTR_BIT_DELTA_EN] &&
                      (st_q.setup[`PTR_BIT_HIGH_EN] || st_q.setup[`PTR_BIT_LOW_EN]); // see RULE_06

  ptr_delta_cmp u_cmp (
    .delta(delta),
    .threshold({st_q.ths_high[6:0], st_q.ths_low}), // see RULE_07
    .high_en(st_q.setup[`PTR_BIT_HIGH_EN]),
    .low_en(st_q.setup[`PTR_BIT_LOW_EN]),
    .high_hit(high_hit),
    .low_hit(low_hit)
  );

  ptr_boot_load u_boot (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .calib_value(calib_value),
    .boot_done(boot_done),
    .calib_q(calib_q)
  );

  always_comb begin
    logic capture;
    logic hi;
    logic lo;
    capture = 1'b0;
    hi = 1'b0;
    lo = 1'b0;
    st_d = st_q;
    // Host writes land first so that hardware updates in the same cycle win.
    if (reg_wr) begin
      unique case (reg_addr) // see RULE_01
        `PTR_OFS_IRQ_SETUP: st_d.setup = reg_wdata;
        `PTR_OFS_THS_LOW: st_d.ths_low = reg_wdata;
        `PTR_OFS_THS_HIGH: st_d.ths_high = {1'b0, reg_wdata[6:0]};
        `PTR_OFS_IF_CTRL: st_d.if_ctrl = reg_wdata;
        `PTR_OFS_CTRL_ONE: st_d.ctrl_one = reg_wdata;
        `PTR_OFS_CTRL_TWO: st_d.ctrl_two = reg_wdata;
        `PTR_OFS_CTRL_THREE: st_d.ctrl_three = reg_wdata;
        `PTR_OFS_FIFO_SETUP: st_d.fifo_setup = reg_wdata;
        `PTR_OFS_FIFO_WATERMARK_LEVEL: st_d.fifo_watermark_level = reg_wdata;
        `PTR_OFS_OFFSET_LOW: st_d.offset_low = reg_wdata;
        `PTR_OFS_OFFSET_HIGH: st_d.offset_high = reg_wdata;
        default: ; // see RULE_02
      endcase
    end
    if (reg_wr && reg_addr == `PTR_OFS_IRQ_SETUP) begin
      if (reg_wdata[`PTR_BIT_CLR_ZEROED] && st_q.mode == ptr_pkg::PTR_REF_ZEROED) begin
        st_d.mode = ptr_pkg::PTR_REF_NONE; // see RULE_15
        st_d.reference = 16'h0000;
      end
      if (reg_wdata[`PTR_BIT_CLR_REF] && st_q.mode == ptr_pkg::PTR_REF_AUTO) begin
        st_d.mode = ptr_pkg::PTR_REF_NONE; // see RULE_18
      end
      // Reset bits act as one-shot commands and do not stay set.
      st_d.setup[`PTR_BIT_CLR_ZEROED] = 1'b0;
      st_d.setup[`PTR_BIT_CLR_REF] = 1'b0;
    end
    // Reading the cause register clears latched events.
    if (reg_rd && reg_addr == `PTR_OFS_IRQ_CAUSE && st_q.setup[`PTR_BIT_LATCH]) begin
      st_d.cause = 3'h0;
    end
    if (conv_done) begin
      st_d.temp_out = conv_temperature;
      if (st_q.setup[`PTR_BIT_ZEROED]) begin
        st_d.reference = conv_pressure[23:8]; // see RULE_12
        st_d.mode = ptr_pkg::PTR_REF_ZEROED;
        st_d.setup[`PTR_BIT_ZEROED] = 1'b0; // see RULE_14
        capture = 1'b1;
      end else if (st_q.setup[`PTR_BIT_AUTO_REF]) begin
        st_d.reference = conv_pressure[23:8]; // see RULE_16
        st_d.mode = ptr_pkg::PTR_REF_AUTO;
        st_d.setup[`PTR_BIT_AUTO_REF] = 1'b0; // see RULE_18
        capture = 1'b1;
      end
      if (capture && st_q.setup[`PTR_BIT_ZEROED]) begin
        st_d.pressure_result = ptr_diff(conv_pressure, {conv_pressure[23:8], 8'h00}); // see RULE_13
      end else if (st_q.mode == ptr_pkg::PTR_REF_ZEROED) begin
        st_d.pressure_result = ptr_diff(conv_pressure, ref_ext); // see RULE_13
      end else begin
        st_d.pressure_result = conv_pressure; // see RULE_17
      end
      hi = cmp_active && !capture && high_hit; // see RULE_19
      lo = cmp_active && !capture && low_hit;
      if (st_q.setup[`PTR_BIT_LATCH]) begin
        st_d.cause[`PTR_CAUSE_HIGH] = st_d.cause[`PTR_CAUSE_HIGH] | hi; // see RULE_10
        st_d.cause[`PTR_CAUSE_LOW] = st_d.cause[`PTR_CAUSE_LOW] | lo;
      end else begin
        st_d.cause[`PTR_CAUSE_HIGH] = hi; // see RULE_10
        st_d.cause[`PTR_CAUSE_LOW] = lo;
      end
      st_d.cause[`PTR_CAUSE_ACTIVE] = st_d.cause[`PTR_CAUSE_HIGH] | st_d.cause[`PTR_CAUSE_LOW];
    end
    st_d.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `PTR_OFS_IRQ_SETUP: st_d.rdata = st_q.setup;
        `PTR_OFS_THS_LOW: st_d.rdata = st_q.ths_low;
        `PTR_OFS_THS_HIGH: st_d.rdata = st_q.ths_high;
        `PTR_OFS_IF_CTRL: st_d.rdata = st_q.if_ctrl;
        `PTR_OFS_IDENTITY: st_d.rdata = IDENTITY_VALUE;
        `PTR_OFS_CTRL_ONE: st_d.rdata = st_q.ctrl_one;
        `PTR_OFS_CTRL_TWO: st_d.rdata = st_q.ctrl_two;
        `PTR_OFS_CTRL_THREE: st_d.rdata = st_q.ctrl_three;
        `PTR_OFS_FIFO_SETUP: st_d.rdata = st_q.fifo_setup;
        `PTR_OFS_FIFO_WATERMARK_LEVEL: st_d.rdata = st_q.fifo_watermark_level;
        `PTR_OFS_REF_LOW: st_d.rdata = st_q.reference[7:0];
        `PTR_OFS_REF_HIGH: st_d.rdata = st_q.reference[15:8];
        `PTR_OFS_OFFSET_LOW: st_d.rdata = st_q.offset_low ^ calib_q[7:0];
        `PTR_OFS_OFFSET_HIGH: st_d.rdata = st_q.offset_high ^ calib_q[15:8];
        `PTR_OFS_IRQ_CAUSE: st_d.rdata = {5'h00, st_q.cause};
        `PTR_OFS_FIFO_ST_ONE: st_d.rdata = fifo_status_one;
        `PTR_OFS_FIFO_ST_TWO: st_d.rdata = fifo_status_two;
        `PTR_OFS_STATUS: st_d.rdata = status_value;
        `PTR_OFS_PRESS_LSB: st_d.rdata = st_q.pressure_result[7:0];
        `PTR_OFS_PRESS_MID: st_d.rdata = st_q.pressure_result[15:8];
        `PTR_OFS_PRESS_MSB: st_d.rdata = st_q.pressure_result[23:16];
        `PTR_OFS_TEMP_LSB: st_d.rdata = st_q.temp_out[7:0];
        `PTR_OFS_TEMP_MSB: st_d.rdata = st_q.temp_out[15:8];
        `PTR_OFS_FILTER_RES: st_d.rdata = 8'h00;
        `PTR_OFS_QP_LSB: st_d.rdata = queued_pressure[7:0];
        `PTR_OFS_QP_MID: st_d.rdata = queued_pressure[15:8];
        `PTR_OFS_QP_MSB: st_d.rdata = queued_pressure[23:16];
        `PTR_OFS_QT_LSB: st_d.rdata = queued_temperature[7:0];
        `PTR_OFS_QT_MSB: st_d.rdata = queued_temperature[15:8];
        default: st_d.rdata = 8'h00; // see RULE_03
      endcase
    end else begin
      st_d.rdata = st_q.rdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0; // see RULE_05
      st_q.ctrl_two <= `PTR_RST_CTRL_TWO;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign ctrl_one = st_q.ctrl_one;
  assign ctrl_two = st_q.ctrl_two;
  assign ctrl_three = st_q.ctrl_three;
  assign fifo_setup = st_q.fifo_setup;
  assign fifo_watermark = st_q.fifo_watermark_level;
  assign interface_ctrl = st_q.if_ctrl;
  assign irq_event = st_q.cause[`PTR_CAUSE_ACTIVE];
endmodule

// *** sim/ptr_regs_monitor.sv ***
// Port checker of the pressure threshold register block.
`timescale 1ns/1ps
`include "ptr_params.svh"
module ptr_regs_monitor #(
  parameter logic [7:0] IDENTITY_VALUE = 8'h5A
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic [7:0] ctrl_one,
  input wire logic [7:0] ctrl_two,
  input wire logic [7:0] fifo_watermark,
  input wire logic irq_event,
  input wire logic boot_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Shadow of the four enable bits, which never clear themselves.
  logic [3:0] en_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en_q <= 4'h0;
    end else if (reg_wr && reg_addr == `PTR_OFS_IRQ_SETUP) begin
      en_q <= reg_wdata[3:0];
    end
  end
  sequence s_cause_read;
    reg_rd && reg_addr == `PTR_OFS_IRQ_CAUSE;
  endsequence
  sequence s_quiet_conv;
    conv_done && !en_q[2] && !(en_q[3] && (en_q[1] || en_q[0]));
  endsequence
  a_reset_values: assert property ($rose(nrst) |-> ctrl_two == 8'h10 && ctrl_one == 8'h00)
    else $error("reset value wrong");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_ctrl_write: assert property (reg_wr && reg_addr == `PTR_OFS_CTRL_ONE |=> ctrl_one == $past(reg_wdata))
    else $error("control write lost");
  a_ctrl_keep: assert property (!(reg_wr && reg_addr == `PTR_OFS_CTRL_ONE) |=> $stable(ctrl_one))
    else $error("control changed");
  a_wtm_write: assert property (reg_wr && reg_addr == `PTR_OFS_FIFO_WATERMARK_LEVEL |=> fifo_watermark == $past(reg_wdata))
    else $error("watermark write lost");
  a_identity_read: assert property (reg_rd && reg_addr == `PTR_OFS_IDENTITY |=> reg_rdata == IDENTITY_VALUE)
    else $error("identity wrong");
  a_cause_irq_match: assert property (s_cause_read |=> reg_rdata[`PTR_CAUSE_ACTIVE] == $past(irq_event))
    else $error("cause and event differ");
  a_irq_after_conv: assert property ($rose(irq_event) |-> $past(conv_done))
    else $error("event without conversion");
  a_irq_gated_off: assert property (s_quiet_conv |=> !irq_event)
    else $error("event while disabled");
  a_boot_done: assert property (1'b1 |=> boot_done)
    else $error("boot not done");
endmodule

bind ptr_regs ptr_regs_monitor #(.IDENTITY_VALUE(IDENTITY_VALUE)) u_mon (
  .clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done), .ctrl_one(ctrl_one),
  .ctrl_two(ctrl_two), .fifo_watermark(fifo_watermark), .irq_event(irq_event),
  .boot_done(boot_done));

// *** sim/ptr_host_model.sv ***
// Host model driving the register port, with a settable idle gap.
`timescale 1ns/1ps
module ptr_host_model (
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata
);
  int gap = 0;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    if (a inside {[7'h1A:7'h23]}) return;
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    repeat (gap) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [6:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    repeat (gap) @(posedge clk_sys);
  endtask
endmodule

// *** sim/pressure_threshold_reference_regs_tb.sv ***
// Self-checking bench of the pressure threshold register block.
`timescale 1ns/1ps
`include "ptr_params.svh"
module pressure_threshold_reference_regs_tb;
  // Arbitrary identity value.
  localparam logic [7:0] ID_V = 8'h3C;
  localparam logic [6:0] RW_A [9] = '{7'h0C, 7'h0D, 7'h0E, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr, reg_rd, conv_done, pend = 1'b0;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, f1, f2, st;
  logic [23:0] conv_pressure, qp;
  logic [15:0] conv_temperature, calib_value, qt, ref_v;
  logic [14:0] ths;
  logic [7:0] exp_q[$];
  int err_total = 0;
  int n_compared = 0;
  always #25 clk_sys = ~clk_sys;
  ptr_host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  ptr_regs #(.IDENTITY_VALUE(ID_V)) DUT (.clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv_done(conv_done), .conv_pressure(conv_pressure), .conv_temperature(conv_temperature),
    .calib_value(calib_value), .fifo_status_one(f1), .fifo_status_two(f2), .status_value(st),
    .queued_pressure(qp), .queued_temperature(qt), .ctrl_one(), .ctrl_two(), .ctrl_three(),
    .fifo_setup(), .fifo_watermark(), .interface_ctrl(), .irq_event(), .boot_done());
  task automatic test_done();
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task automatic conv(input logic [23:0] p);
    @(posedge clk_sys);
    conv_done <= 1'b1;
    conv_pressure <= p;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    conv_pressure <= ~p;
  endtask
  function automatic logic [7:0] cause(input logic [23:0] p, input logic [7:0] en);
    logic signed [24:0] d;
    logic hi, lo;
    d = $signed({1'b0, p}) - $signed({1'b0, ref_v, 8'h00});
    hi = en[3] && en[0] && (d > $signed({10'h000, ths}));
    lo = en[3] && en[1] && (d < $signed({10'h000, ths}));
    return {5'h00, hi | lo, lo, hi};
  endfunction
  // Read data lands one cycle after the strobe, so it is judged at the next falling edge.
  always @(negedge clk_sys) begin
    if (pend) begin
      if (exp_q.size() > 0) cmp8(reg_rdata, exp_q.pop_front());
      else err_total++;
    end
    pend <= reg_rd;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    test_done();
  end
  initial begin
    logic [7:0] d, en, c;
    logic [23:0] p, q;
    conv_done = 1'b0;
    conv_pressure = 24'h000000;
    void'($urandom(22));
    calib_value = 16'($urandom);
    conv_temperature = 16'($urandom);
    f1 = 8'($urandom);
    f2 = 8'($urandom);
    st = 8'($urandom);
    qp = 24'($urandom);
    qt = 16'($urandom);
    ref_v = 16'h0000;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i <= 23; i++) begin
      if (i >= 11 || i == 0) chk(7'(i), i == 15 ? ID_V : (i == 17 ? 8'h10 : 8'h00));
    end
    chk(`PTR_OFS_OFFSET_LOW, calib_value[7:0]);
    chk(`PTR_OFS_OFFSET_HIGH, calib_value[15:8]);
    chk(`PTR_OFS_FIFO_ST_ONE, f1);
    chk(`PTR_OFS_STATUS, st);
    chk(`PTR_OFS_QP_MSB, qp[23:16]);
    chk(`PTR_OFS_QT_LSB, qt[7:0]);
    host.gap = 2;
    for (int i = 0; i < 9; i++) begin
      d = 8'($urandom);
      host.wr(RW_A[i], d);
      chk(RW_A[i], RW_A[i] == 7'h15 ? 8'h00 : d & (RW_A[i] == 7'h0D ? 8'h7F : 8'hFF));
    end
    host.wr(`PTR_OFS_OFFSET_LOW, d);
    chk(`PTR_OFS_OFFSET_LOW, d ^ calib_value[7:0]);
    host.gap = 0;
    ths = 15'($urandom) | 15'h0010;
    host.wr(`PTR_OFS_THS_LOW, ths[7:0]);
    host.wr(`PTR_OFS_THS_HIGH, {1'b0, ths[14:8]});
    host.wr(`PTR_OFS_IRQ_SETUP, 8'h2B);
    // Keeping the captured level between 0x100000 and 0x3FFFFF avoids wrap in every later difference.
    p = (24'($urandom) & 24'h3FFFFF) | 24'h100000;
    conv(p);
    ref_v = p[23:8];
    chk(`PTR_OFS_REF_LOW, ref_v[7:0]);
    chk(`PTR_OFS_REF_HIGH, ref_v[15:8]);
    chk(`PTR_OFS_IRQ_SETUP, 8'h0B);
    for (int k = -1; k <= 1; k++) begin
      p = {ref_v, 8'h00} + 24'(ths) + 24'(k);
      conv(p);
      q = p - {ref_v, 8'h00};
      chk(`PTR_OFS_IRQ_CAUSE, cause(p, 8'h0B));
      for (int b = 0; b < 3; b++) chk(7'(40 + b), q[8 * b +: 8]);
    end
    for (int k = 0; k < 2; k++) begin
      host.wr(`PTR_OFS_IRQ_SETUP, k == 0 ? 8'h03 : 8'h08);
      conv(p ^ 24'h00F0F0);
      chk(`PTR_OFS_IRQ_CAUSE, 8'h00);
    end
    host.wr(`PTR_OFS_IRQ_SETUP, 8'h1B);
    ref_v = 16'h0000;
    chk(`PTR_OFS_REF_HIGH, 8'h00);
    chk(`PTR_OFS_IRQ_SETUP, 8'h0B);
    conv(p);
    chk(`PTR_OFS_PRESS_MSB, p[23:16]);
    en = 8'h0F;
    host.wr(`PTR_OFS_IRQ_SETUP, 8'h8F);
    conv(p);
    ref_v = p[23:8];
    chk(`PTR_OFS_REF_LOW, ref_v[7:0]);
    chk(`PTR_OFS_IRQ_SETUP, en);
    // The raw-mode conversion before latching left a high event, which latching keeps.
    c = 8'h05;
    repeat (3) begin
      p = {ref_v, 8'h00} - 24'(ths) + 24'($urandom_range(0, 2 * int'(ths)));
      conv(p);
      c = c | cause(p, en);
      chk(`PTR_OFS_PRESS_MID, p[15:8]);
    end
    chk(`PTR_OFS_IRQ_CAUSE, c);
    chk(`PTR_OFS_IRQ_CAUSE, 8'h00);
    host.wr(`PTR_OFS_IRQ_SETUP, 8'h4F);
    chk(`PTR_OFS_IRQ_SETUP, en);
    ref_v = 16'h0000;
    p = 24'(ths) + 24'h000001;
    conv(p);
    chk(`PTR_OFS_IRQ_CAUSE, cause(p, en));
    repeat (4) @(posedge clk_sys);
    if (exp_q.size() != 0) err_total++;
    test_done();
  end
endmodule
